// File: logic/tqec_pkg.sv
// Behaviour
// - Bypass bit with coder active routes to coder.
// - Lockstep runs one macroblock, waits coder busy.
// - Transform-only skips quantisation on encode.
// - Inverse-only skips de-quantisation on decode.
// - Soft reset bit clears state, returns idle.
// - Run processes programmed macroblock count unattended.
// - Busy flag reads one while processing.
// - Start bit launches run, clears itself.
// - Format bit one H.263, zero MPEG-4.
// - Direction bit one encode, zero decode.
// - Frame-start applies to first macroblock only.
package tqec_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map and control field layout
	localparam logic [31:0] ENGINE_CONTROL_ADDR = 32'h4900_0034;
	localparam logic [31:0] ENGINE_CONTROL_RST  = 32'h0000_0000;
	localparam int          BIT_COEF_BYPASS     = 29;
	localparam int          BIT_LOCKSTEP        = 28;
	localparam int          BIT_XFORM_ONLY      = 27;
	localparam int          BIT_INV_ONLY        = 26;
	localparam int          BIT_SOFT_RESET      = 25;
	localparam int          MB_COUNT_LSB        = 8;
	localparam int          MB_COUNT_W          = 17;
	localparam int          BIT_BUSY            = 7;
	localparam int          BIT_START           = 6;
	localparam int          BIT_FORMAT          = 4;
	localparam int          BIT_DIRECTION       = 2;
	localparam int          BIT_FRAME_START     = 0;
	// Bits that hold software state; busy, start and soft reset are not stored
	localparam logic [31:0] CTRL_STORE_MASK     = 32'h3DFF_FF15;

	////////////////////////////////////////////////////////////////////////////////
	// Bus answers and data path sizes
	localparam logic [1:0]  RESP_OKAY           = 2'h0;
	localparam logic [1:0]  RESP_DECERR         = 2'h3;
	localparam int          COEF_W              = 32;
	localparam int          FIFO_DEPTH          = 32;
	localparam int          MB_WORD_W           = 9;
	localparam logic [8:0]  MB_WORDS            = 9'h180;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_WAIT_CODER,
		PH_LAUNCH,
		PH_STREAM
	} tqec_phase_type;

	// Per-run mode seen by the transform datapath
	typedef struct packed {
		logic encode;
		logic h263;
		logic quant_skip;
		logic dequant_skip;
	} tqec_cfg_type;

	typedef struct packed {
		tqec_phase_type        phase;
		logic [31:0]           ctrl;
		logic [MB_COUNT_W-1:0] mb_done;
		logic [MB_WORD_W-1:0]  in_cnt;
		logic [MB_WORD_W-1:0]  out_cnt;
		logic                  route_coder;
		logic                  mb_start;
		logic                  frame_start;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [1:0]            rresp;
		logic [31:0]           rdata;
	} tqec_state_type;

endpackage : tqec_pkg

// File: logic/tqec_engine_ctrl.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Coefficient FIFO, flip-flop storage, extra pointer bit tells full from empty
module tqec_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_in,
	input  wire logic             srst_in,
	input  wire logic             clr_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0]                   wr_ptr;
		logic [AW:0]                   rd_ptr;
		logic [DEPTH-1:0][WIDTH-1:0]   mem;
	} tqec_fifo_state_type;

	tqec_fifo_state_type st_ff;
	tqec_fifo_state_type nxt_st;
	logic                full;
	logic                empty;

	// Pointer compare
	assign empty         = (st_ff.wr_ptr == st_ff.rd_ptr);
	assign full          = (st_ff.wr_ptr[AW] != st_ff.rd_ptr[AW]) &&
	                       (st_ff.wr_ptr[AW-1:0] == st_ff.rd_ptr[AW-1:0]);
	assign in_ready_out  = !full;
	assign out_valid_out = !empty;
	assign out_data_out  = st_ff.mem[st_ff.rd_ptr[AW-1:0]];

	// Push and pop; clear drops everything held
	always_comb begin
		nxt_st = st_ff;
		if (in_valid_in && !full) begin
			nxt_st.mem[st_ff.wr_ptr[AW-1:0]] = in_data_in;
			nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
		end
		if (out_ready_in && !empty) begin
			nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
		end
		if (clr_in) begin
			nxt_st.wr_ptr = '0;
			nxt_st.rd_ptr = '0;
		end
	end

	// Storage needs no reset, only the pointers
	always_ff @(posedge clk_in) begin
		st_ff <= nxt_st;
		if (srst_in) begin
			st_ff.wr_ptr <= '0;
			st_ff.rd_ptr <= '0;
		end
	end
endmodule : tqec_fifo

////////////////////////////////////////////////////////////////////////////////
// Transform and quantisation engine sequencer with its control register
module tqec_engine_ctrl
	import tqec_pkg::*;
(
	input  wire logic          clk_in,
	input  wire logic          srst_in,
	input  wire logic [31:0]   s_axi_awaddr_in,
	input  wire logic          s_axi_awvalid_in,
	output logic               s_axi_awready_out,
	input  wire logic [31:0]   s_axi_wdata_in,
	input  wire logic [3:0]    s_axi_wstrb_in,
	input  wire logic          s_axi_wvalid_in,
	output logic               s_axi_wready_out,
	output logic [1:0]         s_axi_bresp_out,
	output logic               s_axi_bvalid_out,
	input  wire logic          s_axi_bready_in,
	input  wire logic [31:0]   s_axi_araddr_in,
	input  wire logic          s_axi_arvalid_in,
	output logic               s_axi_arready_out,
	output logic [31:0]        s_axi_rdata_out,
	output logic [1:0]         s_axi_rresp_out,
	output logic               s_axi_rvalid_out,
	input  wire logic          s_axi_rready_in,
	input  wire logic          coef_valid_in,
	input  wire logic [31:0]   coef_data_in,
	output logic               coef_ready_out,
	output logic               mem_valid_out,
	output logic [31:0]        mem_data_out,
	input  wire logic          mem_ready_in,
	output logic               coder_valid_out,
	output logic [31:0]        coder_data_out,
	input  wire logic          coder_ready_in,
	input  wire logic          coder_active_in,
	input  wire logic          coder_busy_in,
	output logic               mb_start_out,
	output logic               frame_start_out,
	output tqec_cfg_type       cfg_out,
	output logic               engine_busy_out
);

	tqec_state_type st_ff;
	tqec_state_type nxt_st;
	logic           wr_take;
	logic           rd_take;
	logic           wr_hit;
	logic           soft_wr;
	logic           start_wr;
	logic           fifo_in_valid;
	logic           fifo_in_ready;
	logic           fifo_out_valid;
	logic           fifo_out_ready;
	logic [31:0]    fifo_out_data;
	logic           mb_last_out;
	logic [MB_COUNT_W-1:0] mb_total;

	// Byte-lane merge of a register write
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_lanes

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshakes: address and data are taken together, one at a time
	assign s_axi_awready_out = s_axi_awvalid_in && s_axi_wvalid_in && !st_ff.bvalid;
	assign s_axi_wready_out  = s_axi_awready_out;
	assign s_axi_arready_out = !st_ff.rvalid;
	assign s_axi_bvalid_out  = st_ff.bvalid;
	assign s_axi_bresp_out   = st_ff.bresp;
	assign s_axi_rvalid_out  = st_ff.rvalid;
	assign s_axi_rresp_out   = st_ff.rresp;
	assign s_axi_rdata_out   = st_ff.rdata;
	assign wr_take  = s_axi_awready_out;
	assign rd_take  = s_axi_arvalid_in && !st_ff.rvalid;
	assign wr_hit   = wr_take && (s_axi_awaddr_in == ENGINE_CONTROL_ADDR);
	// Self-clearing command bits never land in storage
	assign soft_wr  = wr_hit && s_axi_wstrb_in[3] && s_axi_wdata_in[BIT_SOFT_RESET];
	assign start_wr = wr_hit && s_axi_wstrb_in[0] && s_axi_wdata_in[BIT_START];
	assign mb_total = st_ff.ctrl[MB_COUNT_LSB +: MB_COUNT_W];

	////////////////////////////////////////////////////////////////////////////////
	// Data path routing, memory or straight into the coder's store
	assign fifo_in_valid   = coef_valid_in && (st_ff.phase == PH_STREAM) &&
	                         (st_ff.in_cnt < MB_WORDS);
	assign coef_ready_out  = fifo_in_ready && (st_ff.phase == PH_STREAM) &&
	                         (st_ff.in_cnt < MB_WORDS);
	assign mem_valid_out   = fifo_out_valid && !st_ff.route_coder;
	assign coder_valid_out = fifo_out_valid && st_ff.route_coder;
	assign mem_data_out    = fifo_out_data;
	assign coder_data_out  = fifo_out_data;
	assign fifo_out_ready  = st_ff.route_coder ? coder_ready_in : mem_ready_in;
	assign mb_last_out     = fifo_out_valid && fifo_out_ready &&
	                         (st_ff.out_cnt == MB_WORDS - 9'h001);

	tqec_fifo #(
		.WIDTH (COEF_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_in),
		.srst_in       (srst_in),
		.clr_in        (soft_wr),
		.in_valid_in   (fifo_in_valid),
		.in_data_in    (coef_data_in),
		.in_ready_out  (fifo_in_ready),
		.out_valid_out (fifo_out_valid),
		.out_data_out  (fifo_out_data),
		.out_ready_in  (fifo_out_ready)
	);

	// Mode lines follow the stored bits; quant skips only act in their direction
	assign cfg_out.encode       = st_ff.ctrl[BIT_DIRECTION];
	assign cfg_out.h263         = st_ff.ctrl[BIT_FORMAT];
	assign cfg_out.quant_skip   = st_ff.ctrl[BIT_DIRECTION] && st_ff.ctrl[BIT_XFORM_ONLY];
	assign cfg_out.dequant_skip = !st_ff.ctrl[BIT_DIRECTION] && st_ff.ctrl[BIT_INV_ONLY];
	assign mb_start_out         = st_ff.mb_start;
	assign frame_start_out      = st_ff.frame_start;
	assign engine_busy_out      = (st_ff.phase != PH_IDLE);

	////////////////////////////////////////////////////////////////////////////////
	// Next state: register access, then sequencing; soft reset overrides the sequencing, its register write still lands
	always_comb begin
		nxt_st = st_ff;
		nxt_st.mb_start    = 1'b0;
		nxt_st.frame_start = 1'b0;
		if (st_ff.bvalid && s_axi_bready_in) begin
			nxt_st.bvalid = 1'b0;
		end
		if (st_ff.rvalid && s_axi_rready_in) begin
			nxt_st.rvalid = 1'b0;
		end
		if (wr_take) begin
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = wr_hit ? RESP_OKAY : RESP_DECERR;
		end
		if (wr_hit) begin
			nxt_st.ctrl = merge_lanes(st_ff.ctrl, s_axi_wdata_in, s_axi_wstrb_in) &
			              CTRL_STORE_MASK;
		end
		if (rd_take) begin
			nxt_st.rvalid = 1'b1;
			if (s_axi_araddr_in == ENGINE_CONTROL_ADDR) begin
				nxt_st.rresp = RESP_OKAY;
				nxt_st.rdata = (st_ff.ctrl & CTRL_STORE_MASK) |
				               (32'(engine_busy_out) << BIT_BUSY);
			end else begin
				nxt_st.rresp = RESP_DECERR;
				nxt_st.rdata = 32'h0000_0000;
			end
		end
		if (mb_last_out || (fifo_out_valid && fifo_out_ready)) begin
			nxt_st.out_cnt = st_ff.out_cnt + 9'h001;
		end
		if (fifo_in_valid && fifo_in_ready) begin
			nxt_st.in_cnt = st_ff.in_cnt + 9'h001;
		end
		unique case (st_ff.phase)
			PH_IDLE: begin
				// A start while busy is ignored; a zero count is a no-op
				if (start_wr && (nxt_st.ctrl[MB_COUNT_LSB +: MB_COUNT_W] != '0)) begin
					nxt_st.phase   = PH_WAIT_CODER;
					nxt_st.mb_done = '0;
				end
			end
			PH_WAIT_CODER: begin
				// Lockstep holds each macroblock back while the coder is busy
				if (!(st_ff.ctrl[BIT_LOCKSTEP] && coder_busy_in)) begin
					nxt_st.phase = PH_LAUNCH;
				end
			end
			PH_LAUNCH: begin
				nxt_st.phase       = PH_STREAM;
				nxt_st.mb_start    = 1'b1;
				nxt_st.frame_start = st_ff.ctrl[BIT_FRAME_START] && (st_ff.mb_done == '0);
				nxt_st.route_coder = st_ff.ctrl[BIT_COEF_BYPASS] && coder_active_in;
				nxt_st.in_cnt      = '0;
				nxt_st.out_cnt     = '0;
			end
			PH_STREAM: begin
				// Macroblock ends only when its last word has left the FIFO
				if (mb_last_out) begin
					nxt_st.mb_done = st_ff.mb_done + 17'h00001;
					if (st_ff.mb_done + 17'h00001 == mb_total) begin
						nxt_st.phase = PH_IDLE;
					end else begin
						nxt_st.phase = PH_WAIT_CODER;
					end
				end
			end
		endcase
		if (soft_wr) begin
			nxt_st.phase       = PH_IDLE;
			nxt_st.mb_done     = '0;
			nxt_st.in_cnt      = '0;
			nxt_st.out_cnt     = '0;
			nxt_st.route_coder = 1'b0;
			nxt_st.mb_start    = 1'b0;
			nxt_st.frame_start = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			st_ff       <= '0;
			st_ff.phase <= PH_IDLE;
			st_ff.ctrl  <= ENGINE_CONTROL_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	sequence s_launch;
		(st_ff.phase == PH_LAUNCH) ##1 mb_start_out;
	endsequence

	AST_COEF_ROUTE: assert property (coder_valid_out |-> !mem_valid_out && st_ff.route_coder)
		else $error("coefficients routed to both sinks");
	AST_LOCKSTEP_HOLD: assert property ((st_ff.ctrl[BIT_LOCKSTEP] ##0 s_launch)
		|-> $past(!coder_busy_in, 2))
		else $error("macroblock launched while coder busy");
	AST_QUANT_SKIP: assert property (mb_start_out |-> cfg_out.quant_skip ==
		(st_ff.ctrl[BIT_DIRECTION] && st_ff.ctrl[BIT_XFORM_ONLY]))
		else $error("quantisation skip mismatch");
	AST_DEQUANT_SKIP: assert property (cfg_out.dequant_skip |-> !cfg_out.encode)
		else $error("dequant skip while encoding");
	AST_SOFT_RESET: assert property (soft_wr |=> !engine_busy_out && !fifo_out_valid ##1
		!mb_start_out)
		else $error("soft reset did not idle engine");
	AST_RUN_COUNT: assert property ($fell(engine_busy_out) && !$past(soft_wr)
		|-> st_ff.mb_done == mb_total)
		else $error("run ended at wrong macroblock count");
	AST_START_BUSY: assert property (!engine_busy_out && start_wr &&
		s_axi_wdata_in[MB_COUNT_LSB +: MB_COUNT_W] != '0 && &s_axi_wstrb_in[3:1] && !soft_wr
		|=> engine_busy_out ##1 st_ff.rvalid || !st_ff.ctrl[BIT_START])
		else $error("start did not launch");
	AST_FRAME_FIRST: assert property (frame_start_out |-> mb_start_out &&
		st_ff.mb_done == '0 && st_ff.ctrl[BIT_FRAME_START])
		else $error("frame start outside first macroblock");
	AST_DRAIN_BUSY: assert property ($fell(engine_busy_out) |-> !fifo_out_valid)
		else $error("busy fell with words pending");
	AST_RSVD_ZERO: assert property (s_axi_rvalid_out |-> (s_axi_rdata_out &
		~(CTRL_STORE_MASK | 32'h0000_0080)) == 32'h0000_0000)
		else $error("reserved bits read nonzero");
	AST_MODE_LINES: assert property (cfg_out.h263 == st_ff.ctrl[BIT_FORMAT] &&
		cfg_out.encode == st_ff.ctrl[BIT_DIRECTION])
		else $error("mode lines differ from register");

endmodule : tqec_engine_ctrl

// File: testbench/tqec_coder_model.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Entropy coder store: takes whole macroblocks, then stays busy for a while
module tqec_coder_model #(
	parameter int BUSY_CYC = 20
) (
	input  wire logic clk_in,
	input  wire logic srst_in,
	input  wire logic valid_in,
	input  wire logic stall_in,
	output logic      ready_out,
	output logic      busy_out
);
	logic [8:0] words_ff;
	int         busy_cnt_ff;

	// Busy comes only after a full macroblock, so a lockstep engine must really wait
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			words_ff    <= 9'h000;
			busy_cnt_ff <= 0;
			ready_out   <= 1'b0;
		end else begin
			ready_out <= stall_in ? ~ready_out : 1'b1;
			if (valid_in && ready_out) begin
				words_ff <= (words_ff == 9'h17F) ? 9'h000 : words_ff + 9'h001;
				if (words_ff == 9'h17F)
					busy_cnt_ff <= BUSY_CYC;
			end else if (busy_cnt_ff != 0) begin
				busy_cnt_ff <= busy_cnt_ff - 1;
			end
		end
	end

	// Busy level seen by the engine
	assign busy_out = (busy_cnt_ff != 0);
endmodule : tqec_coder_model

// File: testbench/test_transform_quant_engine_control.sv
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
	$display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module test_transform_quant_engine_control
	import tqec_pkg::*;
;
	logic        clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic [31:0] aw_addr = 32'h0, w_data = 32'h0, ar_addr = 32'h0, coef_data = 32'h0;
	logic [3:0]  w_strb = 4'hF;
	logic        aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0;
	logic        r_ready = 1'b0, coef_valid = 1'b0, mem_ready = 1'b1, coder_active = 1'b0;
	logic        src_on = 1'b0, chk_on = 1'b1, stall = 1'b0;
	logic [1:0]  mem_mode = 2'h0, resp;
	logic [31:0] rd, out_exp = 32'h0;
	wire logic   aw_rdy, w_rdy, b_valid, ar_rdy, r_valid, coef_rdy, mem_valid, coder_valid;
	wire logic   coder_rdy, coder_busy, mb_start, frame_start, busy;
	wire logic [1:0]  b_resp, r_resp;
	wire logic [31:0] r_data, mem_data, coder_data;
	wire tqec_cfg_type cfg;
	int errors = 0, total_checks = 0, cyc = 0;
	int in_n = 0, mem_n = 0, cod_n = 0, mb_n = 0, fs_n = 0, lock_bad = 0;

	tqec_engine_ctrl i_tqec_engine_ctrl (
		.clk_in(clk_in), .srst_in(srst_in),
		.s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid), .s_axi_awready_out(aw_rdy),
		.s_axi_wdata_in(w_data), .s_axi_wstrb_in(w_strb), .s_axi_wvalid_in(w_valid),
		.s_axi_wready_out(w_rdy), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_valid),
		.s_axi_bready_in(b_ready), .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid),
		.s_axi_arready_out(ar_rdy), .s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp),
		.s_axi_rvalid_out(r_valid), .s_axi_rready_in(r_ready),
		.coef_valid_in(coef_valid), .coef_data_in(coef_data), .coef_ready_out(coef_rdy),
		.mem_valid_out(mem_valid), .mem_data_out(mem_data), .mem_ready_in(mem_ready),
		.coder_valid_out(coder_valid), .coder_data_out(coder_data), .coder_ready_in(coder_rdy),
		.coder_active_in(coder_active), .coder_busy_in(coder_busy), .mb_start_out(mb_start),
		.frame_start_out(frame_start), .cfg_out(cfg), .engine_busy_out(busy)
	);

	tqec_coder_model i_tqec_coder_model (
		.clk_in(clk_in), .srst_in(srst_in), .valid_in(coder_valid), .stall_in(stall),
		.ready_out(coder_rdy), .busy_out(coder_busy)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	always #2 clk_in = ~clk_in;

	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			wrap_up();
		end
	end

	// Counting source; valid holds until taken even when switched off
	// Whole macroblocks are run except the one t_decode cuts short by soft reset, as for an image of whole 16x16 tiles
	always @(posedge clk_in) begin
		if (coef_valid && coef_rdy) begin
			coef_data <= coef_data + 32'h1;
			in_n++;
		end
		if (!coef_valid || coef_rdy)
			coef_valid <= src_on;
	end

	// Memory sink: always ready, held off, or stalling every other cycle
	always @(posedge clk_in) mem_ready <= (mem_mode == 2'h0) | ((mem_mode == 2'h2) & ~mem_ready);

	// Output monitor; data must leave in the order it came in, on either route
	always @(posedge clk_in) begin
		if (mb_start === 1'b1)
			mb_n++;
		if (frame_start === 1'b1)
			fs_n++;
		if (mb_start === 1'b1 && coder_busy === 1'b1)
			lock_bad++;
		if ((mem_valid && mem_ready) || (coder_valid && coder_rdy)) begin
			if (chk_on) `CHK(mem_valid ? mem_data : coder_data, out_exp)
			out_exp <= out_exp + 32'h1;
			if (mem_valid && mem_ready)
				mem_n++;
			else
				cod_n++;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus tasks
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		aw_addr <= a;
		w_data <= d;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		@(posedge clk_in iff (aw_rdy === 1'b1 && w_rdy === 1'b1));
		aw_valid <= 1'b0;
		w_valid <= 1'b0;
		@(posedge clk_in iff b_valid === 1'b1);
		r = b_resp;
		b_ready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		ar_addr <= a;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		@(posedge clk_in iff ar_rdy === 1'b1);
		ar_valid <= 1'b0;
		@(posedge clk_in iff r_valid === 1'b1);
		d = r_data;
		r = r_resp;
		r_ready <= 1'b0;
	endtask : axi_rd

	task automatic soft_rst;
		axi_wr(ENGINE_CONTROL_ADDR, 32'h0200_0000, resp);
	endtask : soft_rst

	task automatic wait_idle;
		@(posedge clk_in iff busy === 1'b0);
		@(negedge clk_in);
	endtask : wait_idle

	task automatic clr;
		in_n = 0;
		mem_n = 0;
		cod_n = 0;
		mb_n = 0;
		fs_n = 0;
		lock_bad = 0;
	endtask : clr

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs;
		axi_rd(ENGINE_CONTROL_ADDR, rd, resp);
		`CHK(rd, 32'h0)
		axi_rd(32'h4900_0038, rd, resp);
		`CHK({resp, rd}, {2'h3, 32'h0})
		axi_wr(32'h4900_0038, 32'h1, resp);
		`CHK(resp, 2'h3)
		// Soft reset in the same write beats start, so nothing runs
		axi_wr(ENGINE_CONTROL_ADDR, 32'hFFFF_FFFF, resp);
		axi_rd(ENGINE_CONTROL_ADDR, rd, resp);
		`CHK(rd, 32'h3DFF_FF15)
		`CHK(busy, 1'b0)
		axi_wr(ENGINE_CONTROL_ADDR, 32'h0, resp);
	endtask : t_regs

	task automatic t_run_mem;
		clr();
		soft_rst();
		mem_mode <= 2'h1;
		src_on <= 1'b1;
		axi_wr(ENGINE_CONTROL_ADDR, 32'h0800_0255, resp);
		axi_rd(ENGINE_CONTROL_ADDR, rd, resp);
		`CHK(rd, 32'h0800_0295)
		`CHK(cfg, 4'hE)
		repeat (80) @(negedge clk_in);
		`CHK({coef_rdy, in_n}, {1'b0, 32'd32})
		mem_mode = 2'h2;
		wait_idle();
		`CHK(mem_n, 768)
		`CHK(mb_n, 2)
		`CHK(fs_n, 1)
	endtask : t_run_mem

	task automatic t_decode;
		clr();
		soft_rst();
		axi_wr(ENGINE_CONTROL_ADDR, 32'h0400_0140, resp);
		`CHK(cfg, 4'h1)
		repeat (100) @(posedge clk_in);
		chk_on <= 1'b0;
		axi_wr(ENGINE_CONTROL_ADDR, 32'h0600_0100, resp);
		@(negedge clk_in);
		`CHK(busy, 1'b0)
		axi_rd(ENGINE_CONTROL_ADDR, rd, resp);
		`CHK(rd, 32'h0400_0100)
		// Flushed words are gone; the next one taken starts the sequence again
		out_exp <= coef_data;
		chk_on <= 1'b1;
		clr();
		axi_wr(ENGINE_CONTROL_ADDR, 32'h0400_0140, resp);
		wait_idle();
		`CHK(mem_n, 384)
		`CHK({mb_n, fs_n}, {32'd1, 32'd0})
	endtask : t_decode

	task automatic t_coder;
		clr();
		soft_rst();
		coder_active <= 1'b1;
		stall <= 1'b1;
		axi_wr(ENGINE_CONTROL_ADDR, 32'h3000_0244, resp);
		wait_idle();
		`CHK({cod_n, mem_n}, {32'd768, 32'd0})
		`CHK({mb_n, lock_bad}, {32'd2, 32'd0})
	endtask : t_coder

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and main sequence
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (16) @(posedge clk_in);
		srst_in <= 1'b0;
		t_regs();
		t_run_mem();
		t_decode();
		t_coder();
		wrap_up();
	end
endmodule : test_transform_quant_engine_control
